// file: core/mdu_core.sv
// Purpose: Multiply, multiply-accumulate and divide unit on the peripheral register bus
// Assumes: One clock mclk; bus inputs come from logic on mclk
// Notes: Reads answer one clock after sfrRd; writes take a per-bit mask
// Notes on behaviour
// - Control register is eight bits and clears to zero, unsigned multiply.
// - Control bits: 7 divide, 6 accumulate, 3 signed, 2 overflow, 1 sign, 0 busy.
// - Modes: 000 mul, 001 smul, 010 mac, 011 smac, 1x0 divide; others prohibited.
// - Division completion interrupt only when the accumulate bit is zero.
// - Unsigned accumulate sets overflow when the sum leaves 32-bit unsigned range.
// - Signed accumulate overflow when like-signed operands give an opposite-signed sum.
// - Sign flag follows accumulated bit 31 in signed accumulate, else zero.
// - Overflow and sign flags are read-only.
// - Start bit takes a one only in divide mode; cleared by hardware at the end.
// - Writing zero to the busy bit during a division is ignored.
// - Control register accepts single-bit and whole-byte writes.
// - Multiply starts once both operand-A halves are written, any order.
// - Product lands in operand B one clock after the start.
// - Signed multiply treats operands and product as two's complement.
// - Accumulate starts on the multiplier write alone.
// - Accumulate: product after one clock, sum in C one clock later.
// - Accumulate overflow sets the overflow flag and raises the interrupt.
// - Division finishes within sixteen clocks; quotient to A, remainder to C.
// - A holds dividend then quotient; B holds the divisor.
// - Multiply and accumulate products go to the B pair.
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defines.svh"
module mdu_core
	import mdu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [19:0] sfrAddr,
	input wire logic sfrWr,
	input wire logic [15:0] sfrWrMask,
	input wire logic [15:0] sfrWrData,
	input wire logic sfrRd,
	output logic [15:0] rdData,
	output logic arithIrq
);
	mdu_state_t s_r;
	mdu_state_t s_nxt;
	mdu_div_if dvb();

	mdu_divider i_mdu_divider (
		.mclk(mclk),
		.rst_n(rst_n),
		.dv(dvb.div)
	);

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [15:0] m);
		merge = (old & ~m) | (wd & m);
	endfunction

	logic [7:0] ctrlView;
	logic [31:0] extLow;
	logic [31:0] extHigh;
	logic [31:0] prodW;
	logic [32:0] sumW;
	logic ovfW;
	logic ctrlWr;
	logic divStart;

	assign ctrlView = {s_r.divSel, s_r.accSel, 2'b00, s_r.sgnSel, s_r.ovf, s_r.sgnFlag,
		s_r.busy};
	assign ctrlWr = sfrWr && (sfrAddr == `MDU_ADDR_CTRL);

	// Sign or zero extension to 32 bits keeps the low 32 product bits exact either way
	assign extLow = s_r.sgnSel ? {{16{s_r.opA[15]}}, s_r.opA[15:0]} : {16'h0000, s_r.opA[15:0]};
	assign extHigh = s_r.sgnSel ? {{16{s_r.opA[31]}}, s_r.opA[31:16]} : {16'h0000, s_r.opA[31:16]};
	assign prodW = 32'(extLow * extHigh);
	assign sumW = {1'b0, s_r.opC} + {1'b0, s_r.opB};
	always_comb begin
		if (s_r.sgnSel) begin
			ovfW = (s_r.opB[31] == s_r.opC[31]) && (sumW[31] != s_r.opC[31]);
		end else begin
			ovfW = sumW[32];
		end
	end

	assign dvb.start = divStart;
	assign dvb.dividend = s_r.opA;
	assign dvb.divisor = s_r.opB;

	always_comb begin
		logic [7:0] wv;
		logic mulMode;
		logic accumulate_select;
		logic aWr;
		wv = ctrlView;
		mulMode = 1'b0;
		accumulate_select = 1'b0;
		aWr = 1'b0;
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.mulGo = 1'b0;
		s_nxt.macAdd = 1'b0;
		divStart = 1'b0;
		if (sfrRd) begin
			unique case (sfrAddr)
				`MDU_ADDR_CTRL: s_nxt.rdData = {8'h00, ctrlView};
				`MDU_ADDR_AL: s_nxt.rdData = s_r.opA[15:0];
				`MDU_ADDR_AH: s_nxt.rdData = s_r.opA[31:16];
				`MDU_ADDR_BL: s_nxt.rdData = s_r.opB[15:0];
				`MDU_ADDR_BH: s_nxt.rdData = s_r.opB[31:16];
				`MDU_ADDR_CL: s_nxt.rdData = s_r.opC[15:0];
				`MDU_ADDR_CH: s_nxt.rdData = s_r.opC[31:16];
				default: s_nxt.rdData = 16'h0000;
			endcase
		end
		if (ctrlWr) begin
			wv = 8'(merge({8'h00, ctrlView}, sfrWrData, sfrWrMask));
			// Flags and bits 5..4 are not taken from the write
			s_nxt.divSel = wv[`MDU_BIT_DIV];
			s_nxt.accSel = wv[`MDU_BIT_ACC];
			s_nxt.sgnSel = wv[`MDU_BIT_SGN];
			if (!s_r.busy && wv[`MDU_BIT_BUSY] && wv[`MDU_BIT_DIV] && !wv[`MDU_BIT_SGN]) begin
				s_nxt.busy = 1'b1;
				divStart = 1'b1;
			end
		end
		mulMode = !s_nxt.divSel && !s_nxt.accSel;
		accumulate_select = !s_nxt.divSel && s_nxt.accSel;
		if (sfrWr) begin
			unique case (sfrAddr)
				`MDU_ADDR_AL: begin
					s_nxt.opA[15:0] = merge(s_r.opA[15:0], sfrWrData, sfrWrMask);
					s_nxt.gotLow = 1'b1;
					aWr = 1'b1;
				end
				`MDU_ADDR_AH: begin
					s_nxt.opA[31:16] = merge(s_r.opA[31:16], sfrWrData, sfrWrMask);
					s_nxt.gotHigh = 1'b1;
					aWr = 1'b1;
					if (accumulate_select) begin
						s_nxt.mulGo = 1'b1;
					end
				end
				`MDU_ADDR_BL: s_nxt.opB[15:0] = merge(s_r.opB[15:0], sfrWrData, sfrWrMask);
				`MDU_ADDR_BH: s_nxt.opB[31:16] = merge(s_r.opB[31:16], sfrWrData, sfrWrMask);
				`MDU_ADDR_CL: s_nxt.opC[15:0] = merge(s_r.opC[15:0], sfrWrData, sfrWrMask);
				`MDU_ADDR_CH: s_nxt.opC[31:16] = merge(s_r.opC[31:16], sfrWrData, sfrWrMask);
				default: begin
				end
			endcase
		end
		// Any operand-A write restarts once both halves are known, so a repeat may skip the
		// multiplicand; a multiplier written first gives a product that the next write fixes
		if (mulMode && aWr && s_nxt.gotLow && s_nxt.gotHigh) begin
			s_nxt.mulGo = 1'b1;
		end
		if (s_nxt.mulGo) begin
			s_nxt.accumulate = accumulate_select;
		end
		if (accumulate_select && s_nxt.mulGo) begin
			s_nxt.gotLow = 1'b0;
			s_nxt.gotHigh = 1'b0;
		end
		if (s_r.mulGo) begin
			s_nxt.opB = prodW;
			s_nxt.macAdd = s_r.accumulate;
		end
		if (s_r.macAdd) begin
			s_nxt.opC = sumW[31:0];
			s_nxt.ovf = ovfW;
			s_nxt.irq = ovfW;
		end
		if (dvb.done) begin
			s_nxt.opA = dvb.quotient;
			s_nxt.opC = dvb.remainder;
			s_nxt.busy = 1'b0;
			s_nxt.irq = !s_r.accSel;
		end
		if (s_r.busy) begin
			s_nxt.busy = s_nxt.busy | !dvb.done;
		end
		s_nxt.sgnFlag = !s_nxt.divSel && s_nxt.accSel && s_nxt.sgnSel && s_nxt.opC[31];
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdData = s_r.rdData;
	assign arithIrq = s_r.irq;

	logic rdCtrl_r;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdCtrl_r <= 1'b0;
		end else begin
			rdCtrl_r <= sfrRd && (sfrAddr == `MDU_ADDR_CTRL);
		end
	end

	property p_reserved_zero;
		@(posedge mclk) disable iff (!rst_n) rdCtrl_r |-> rdData[5:4] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved control bits read nonzero");

	property p_busy_only_div;
		@(posedge mclk) disable iff (!rst_n) $rose(s_r.busy) |-> s_r.divSel && !s_r.sgnSel;
	endproperty
	a_busy_only_div: assert property (p_busy_only_div)
		else $error("division started outside divide mode");

	property p_div_sixteen;
		@(posedge mclk) disable iff (!rst_n)
			$rose(s_r.busy) |-> s_r.busy[*8] ##1 s_r.busy[*8] ##1 !s_r.busy;
	endproperty
	a_div_sixteen: assert property (p_div_sixteen)
		else $error("division busy not exactly sixteen clocks");

	property p_busy_holds;
		@(posedge mclk) disable iff (!rst_n)
			s_r.busy && ctrlWr && !dvb.done |=> s_r.busy;
	endproperty
	a_busy_holds: assert property (p_busy_holds)
		else $error("busy bit cleared by software");

	property p_div_irq;
		@(posedge mclk) disable iff (!rst_n) $fell(s_r.busy) |-> arithIrq == !s_r.accSel;
	endproperty
	a_div_irq: assert property (p_div_irq)
		else $error("division interrupt does not follow accumulate bit");

	property p_product;
		@(posedge mclk) disable iff (!rst_n) s_r.mulGo |=> s_r.opB == $past(prodW);
	endproperty
	a_product: assert property (p_product)
		else $error("product not in operand B one clock after start");

	property p_mac_two;
		@(posedge mclk) disable iff (!rst_n)
			s_r.mulGo && s_r.accumulate |-> ##1 s_r.macAdd
			##1 s_r.opC == 32'($past(s_r.opC) + $past(s_r.opB));
	endproperty
	a_mac_two: assert property (p_mac_two)
		else $error("accumulated sum not in C two clocks after start");

	property p_ovf_irq;
		@(posedge mclk) disable iff (!rst_n) s_r.macAdd && ovfW |=> s_r.ovf && arithIrq;
	endproperty
	a_ovf_irq: assert property (p_ovf_irq)
		else $error("overflow did not set flag and interrupt");

	property p_sign_flag;
		@(posedge mclk) disable iff (!rst_n)
			s_r.sgnFlag |-> s_r.accSel && s_r.sgnSel && !s_r.divSel && s_r.opC[31];
	endproperty
	a_sign_flag: assert property (p_sign_flag)
		else $error("sign flag set without signed negative accumulation");

	property p_flags_ro;
		@(posedge mclk) disable iff (!rst_n) ctrlWr && !s_r.macAdd |=> $stable(s_r.ovf);
	endproperty
	a_flags_ro: assert property (p_flags_ro)
		else $error("overflow flag changed by software write");

	property p_cov_mul;
		@(posedge mclk) disable iff (!rst_n) s_r.mulGo && !s_r.accumulate;
	endproperty
	c_cov_mul: cover property (p_cov_mul);

	property p_cov_mac_ovf;
		@(posedge mclk) disable iff (!rst_n) s_r.macAdd && ovfW;
	endproperty
	c_cov_mac_ovf: cover property (p_cov_mac_ovf);

	property p_cov_div;
		@(posedge mclk) disable iff (!rst_n) $fell(s_r.busy);
	endproperty
	c_cov_div: cover property (p_cov_div);

	property p_mul_start;
		@(posedge mclk) disable iff (!rst_n)
			sfrWr && (sfrAddr == `MDU_ADDR_AH) && !s_r.divSel && !s_r.accSel && s_r.gotLow
			|=> s_r.mulGo && !s_r.accumulate;
	endproperty
	a_mul_start: assert property (p_mul_start)
		else $error("multiply did not start on multiplier write");

	property p_mac_start;
		@(posedge mclk) disable iff (!rst_n)
			sfrWr && (sfrAddr == `MDU_ADDR_AH) && !s_r.divSel && s_r.accSel
			|=> s_r.mulGo && s_r.accumulate;
	endproperty
	a_mac_start: assert property (p_mac_start)
		else $error("accumulate did not start on multiplier write");

	property p_div_result;
		@(posedge mclk) disable iff (!rst_n)
			dvb.done |=> !s_r.busy && s_r.opA == $past(dvb.quotient)
			&& s_r.opC == $past(dvb.remainder);
	endproperty
	a_div_result: assert property (p_div_result)
		else $error("division result not in A and C at completion");

	property p_cov_sign;
		@(posedge mclk) disable iff (!rst_n) $rose(s_r.sgnFlag);
	endproperty
	c_cov_sign: cover property (p_cov_sign);

	property p_cov_div_quiet;
		@(posedge mclk) disable iff (!rst_n) $fell(s_r.busy) && s_r.accSel;
	endproperty
	c_cov_div_quiet: cover property (p_cov_div_quiet);
endmodule
`default_nettype wire

// file: core/mdu_defines.svh
// Purpose: Addresses, bit positions, reset values and counts of the arithmetic unit
// Assumes: 20-bit peripheral address space, 16-bit data path
// Notes: Definitions only
`ifndef MDU_DEFINES_SVH
`define MDU_DEFINES_SVH

`define MDU_ADDR_W 20
`define MDU_ADDR_CTRL 20'hF00E8
`define MDU_ADDR_AL 20'hF00F0
`define MDU_ADDR_AH 20'hF00F2
`define MDU_ADDR_BL 20'hF00F4
`define MDU_ADDR_BH 20'hF00F6
`define MDU_ADDR_CL 20'hF00F8
`define MDU_ADDR_CH 20'hF00FA

`define MDU_BIT_DIV 7
`define MDU_BIT_ACC 6
`define MDU_BIT_SGN 3
`define MDU_BIT_OVF 2
`define MDU_BIT_SFLAG 1
`define MDU_BIT_BUSY 0

`define MDU_CTRL_RST 8'h00
`define MDU_DATA_RST 32'h0000_0000
`define MDU_DIV_CYCLES 5'h10

`endif

// file: core/mdu_pkg.sv
// Purpose: Types shared by the arithmetic unit and its divider
// Assumes: Nothing beyond the defines header
// Notes: State of each module is one packed struct
package mdu_pkg;

	typedef struct packed {
		logic divSel;
		logic accSel;
		logic sgnSel;
		logic ovf;
		logic sgnFlag;
		logic busy;
		logic gotLow;
		logic gotHigh;
		logic mulGo;
		logic accumulate;
		logic macAdd;
		logic irq;
		logic [31:0] opA;
		logic [31:0] opB;
		logic [31:0] opC;
		logic [15:0] rdData;
	} mdu_state_t;

	typedef struct packed {
		logic [31:0] rem;
		logic [31:0] quo;
		logic [31:0] den;
		logic [4:0] cnt;
		logic done;
	} mdu_div_state_t;

endpackage

// file: core/mdu_div_if.sv
// Purpose: Carries a division request and its result between core and divider
// Assumes: Both ends on mclk
// Notes: start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface mdu_div_if;
	logic start;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic done;
	logic [31:0] quotient;
	logic [31:0] remainder;

	modport core (output start, output dividend, output divisor,
		input done, input quotient, input remainder);
	modport div (input start, input dividend, input divisor,
		output done, output quotient, output remainder);
endinterface
`default_nettype wire

// file: core/mdu_divider.sv
// Purpose: 32 by 32 unsigned restoring divider, two quotient bits per clock
// Assumes: Operands are sampled in the cycle of the start pulse
// Notes: done pulses 15 clocks after the start edge; divisor zero gives garbage
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defines.svh"
module mdu_divider
	import mdu_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	mdu_div_if.div dv
);
	mdu_div_state_t s_r;
	mdu_div_state_t s_nxt;

	function automatic logic [63:0] divStep(input logic [31:0] rem, input logic [31:0] quo,
		input logic [31:0] den);
		logic [32:0] t;
		t = {rem, quo[31]};
		if (t >= {1'b0, den}) begin
			divStep = {32'(t - {1'b0, den}), quo[30:0], 1'b1};
		end else begin
			divStep = {t[31:0], quo[30:0], 1'b0};
		end
	endfunction

	logic [63:0] step1;
	logic [63:0] step2;

	always_comb begin
		logic [31:0] r;
		logic [31:0] q;
		logic [31:0] d;
		r = s_r.rem;
		q = s_r.quo;
		d = s_r.den;
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		// First step runs in the start cycle itself so 16 clocks cover 32 bits
		if (dv.start) begin
			r = 32'h0000_0000;
			q = dv.dividend;
			d = dv.divisor;
			s_nxt.den = dv.divisor;
			s_nxt.cnt = `MDU_DIV_CYCLES;
		end
		step1 = divStep(r, q, d);
		step2 = divStep(step1[63:32], step1[31:0], d);
		if (s_nxt.cnt != 5'h00) begin
			s_nxt.rem = step2[63:32];
			s_nxt.quo = step2[31:0];
			s_nxt.cnt = s_nxt.cnt - 5'h01;
			s_nxt.done = (s_nxt.cnt == 5'h00);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign dv.done = s_r.done;
	assign dv.quotient = s_r.quo;
	assign dv.remainder = s_r.rem;
endmodule
`default_nettype wire

// file: tb/mdu_cpu_model.sv
// Purpose: Processor side of the peripheral register bus for the arithmetic unit
// Assumes: Requests launched at the falling edge, taken at the next rising edge
// Notes: Idle data and address carry the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module mdu_cpu_model (
	input wire logic mclk,
	output logic [19:0] sfrAddr,
	output logic sfrWr,
	output logic [15:0] sfrWrMask,
	output logic [15:0] sfrWrData,
	output logic sfrRd,
	input wire logic [15:0] rdData
);
	initial begin
		sfrAddr = 20'h00000;
		sfrWr = 1'b0;
		sfrWrMask = 16'h0000;
		sfrWrData = 16'h0000;
		sfrRd = 1'b0;
	end

	// One-hot mask gives a bit write, 16'h00FF a byte write
	task automatic wr(input logic [19:0] a, input logic [15:0] m, input logic [15:0] d);
		@(negedge mclk);
		sfrAddr = a;
		sfrWrMask = m;
		sfrWrData = d;
		sfrWr = 1'b1;
		@(negedge mclk);
		sfrWr = 1'b0;
		sfrWrMask = 16'h0000;
		// Stale values must never look like a valid request
		sfrWrData = ~d;
		sfrAddr = ~a;
	endtask

	task automatic rd(input logic [19:0] a, output logic [15:0] d);
		@(negedge mclk);
		sfrAddr = a;
		sfrRd = 1'b1;
		@(negedge mclk);
		sfrRd = 1'b0;
		sfrAddr = ~a;
		d = rdData;
	endtask
endmodule
`default_nettype wire

// file: tb/test_mul_div_mac_unit.sv
// Purpose: Self-checking bench of the multiply, accumulate and divide unit
// Assumes: 10 MHz mclk, bus driven at the falling edge by the processor model
// Notes: Expected values are worked out by hand from the operands
`timescale 1ns/10ps
`default_nettype none
`include "mdu_defines.svh"
`define CHK(g, e) cmp(32'(g), 32'(e))
module test_mul_div_mac_unit;
	logic mclk;
	logic rst_n;
	logic [19:0] sfrAddr;
	logic sfrWr;
	logic [15:0] sfrWrMask;
	logic [15:0] sfrWrData;
	logic sfrRd;
	logic [15:0] rdData;
	logic arithIrq;
	int failures = 0;
	int n_tests = 0;
	int irqCnt = 0;
	int cyc = 0;

	mdu_core i_mdu_core (.mclk(mclk), .rst_n(rst_n), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
		.sfrWrMask(sfrWrMask), .sfrWrData(sfrWrData), .sfrRd(sfrRd), .rdData(rdData),
		.arithIrq(arithIrq));
	mdu_cpu_model i_mdu_cpu_model (.mclk(mclk), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
		.sfrWrMask(sfrWrMask), .sfrWrData(sfrWrData), .sfrRd(sfrRd), .rdData(rdData));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Counting high edges also proves the request is a single pulse
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (arithIrq === 1'b1) irqCnt <= irqCnt + 1;
	end

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	task automatic wr(input logic [19:0] a, input logic [15:0] m, input logic [15:0] d);
		i_mdu_cpu_model.wr(a, m, d);
	endtask

	task automatic wr32(input logic [19:0] a, input logic [31:0] v);
		wr(a, 16'hFFFF, v[15:0]);
		wr(a + 20'h00002, 16'hFFFF, v[31:16]);
	endtask

	// High half first, the reverse of the write order
	task automatic chk32(input logic [19:0] a, input logic [31:0] e);
		logic [15:0] lo;
		logic [15:0] hi;
		i_mdu_cpu_model.rd(a + 20'h00002, hi);
		i_mdu_cpu_model.rd(a, lo);
		`CHK({hi, lo}, e);
	endtask

	task automatic chkCtrl(input logic [7:0] e);
		logic [15:0] d;
		i_mdu_cpu_model.rd(`MDU_ADDR_CTRL, d);
		`CHK(d, {8'h00, e});
	endtask

	task automatic mulCase(input logic [7:0] md, input logic [15:0] l, input logic [15:0] h,
		input logic [31:0] e, input bit swap);
		wr(`MDU_ADDR_CTRL, 16'h00FF, {8'h00, md});
		if (swap) begin
			wr(`MDU_ADDR_AH, 16'hFFFF, h);
			wr(`MDU_ADDR_AL, 16'hFFFF, l);
		end else begin
			wr(`MDU_ADDR_AL, 16'hFFFF, l);
			wr(`MDU_ADDR_AH, 16'hFFFF, h);
		end
		idle(2);
		chk32(`MDU_ADDR_BL, e);
		chkCtrl(md);
	endtask

	task automatic macStep(input logic [15:0] l, input logic [15:0] h, input logic [31:0] c,
		input logic [7:0] cr, input int irqInc);
		int i0;
		i0 = irqCnt;
		wr(`MDU_ADDR_AL, 16'hFFFF, l);
		wr(`MDU_ADDR_AH, 16'hFFFF, h);
		idle(3);
		chk32(`MDU_ADDR_CL, c);
		chkCtrl(cr);
		`CHK(irqCnt - i0, irqInc);
	endtask

	task automatic divCase(input logic [7:0] md, input logic [31:0] n, input logic [31:0] dv,
		input logic [31:0] q, input logic [31:0] r, input int irqInc);
		int i0;
		int t0;
		logic [15:0] d;
		wr(`MDU_ADDR_CTRL, 16'h00FF, {8'h00, md});
		wr32(`MDU_ADDR_AL, n);
		wr32(`MDU_ADDR_BL, dv);
		i0 = irqCnt;
		wr(`MDU_ADDR_CTRL, 16'h0001, 16'h0001);
		t0 = cyc;
		chkCtrl(md | 8'h01);
		wr(`MDU_ADDR_CTRL, 16'h0001, 16'h0000);
		chkCtrl(md | 8'h01);
		// Mode bits stay put while busy; results would be undefined otherwise
		d = 16'h0001;
		for (int i = 0; i < 12 && d[0] !== 1'b0; i++) i_mdu_cpu_model.rd(`MDU_ADDR_CTRL, d);
		`CHK(d, {8'h00, md});
		`CHK(cyc - t0 <= 18, 1);
		chk32(`MDU_ADDR_AL, q);
		chk32(`MDU_ADDR_CL, r);
		`CHK(irqCnt - i0, irqInc);
	endtask

	task automatic tReset;
		chkCtrl(8'h00);
		chk32(`MDU_ADDR_AL, 32'h00000000);
		chk32(`MDU_ADDR_BL, 32'h00000000);
		chk32(`MDU_ADDR_CL, 32'h00000000);
	endtask

	task automatic tMul;
		mulCase(8'h00, 16'h0002, 16'h0003, 32'h00000006, 1'b0);
		mulCase(8'h00, 16'hFFFF, 16'hFFFF, 32'hFFFE0001, 1'b1);
		mulCase(8'h08, 16'hFFFE, 16'h7FFF, 32'hFFFF0002, 1'b0);
		mulCase(8'h08, 16'hFFFF, 16'hFFFF, 32'h00000001, 1'b1);
		// Same mode again: only the multiplier is rewritten
		wr(`MDU_ADDR_AH, 16'hFFFF, 16'h0002);
		idle(2);
		chk32(`MDU_ADDR_BL, 32'hFFFFFFFE);
		// Reserved and flag bits ignore writes, start refused outside divide mode
		wr(`MDU_ADDR_CTRL, 16'h00FF, 16'h0037);
		chkCtrl(8'h00);
		wr(`MDU_ADDR_CTRL, 16'h00FF, 16'h0088);
		wr(`MDU_ADDR_CTRL, 16'h0001, 16'h0001);
		chkCtrl(8'h88);
	endtask

	task automatic tMac;
		wr(`MDU_ADDR_CTRL, 16'h00FF, 16'h0040);
		wr32(`MDU_ADDR_CL, 32'h00000003);
		macStep(16'h0002, 16'h0003, 32'h00000009, 8'h40, 0);
		chk32(`MDU_ADDR_BL, 32'h00000006);
		wr32(`MDU_ADDR_CL, 32'hFFFF0002);
		macStep(16'h7FFF, 16'h0002, 32'h00000000, 8'h44, 1);
		wr(`MDU_ADDR_CTRL, 16'h0004, 16'h0000);
		wr(`MDU_ADDR_CTRL, 16'h00FF, 16'h0040);
		chkCtrl(8'h44);
		// Repeat without setup: only the multiplier is rewritten
		wr(`MDU_ADDR_AH, 16'hFFFF, 16'h0001);
		idle(3);
		chk32(`MDU_ADDR_CL, 32'h00007FFF);
	endtask

	task automatic tSmac;
		wr(`MDU_ADDR_CTRL, 16'h00FF, 16'h0048);
		wr32(`MDU_ADDR_CL, 32'hFFFFFFFC);
		macStep(16'h0002, 16'h0003, 32'h00000002, 8'h48, 0);
		macStep(16'h0001, 16'hFFFB, 32'hFFFFFFFD, 8'h4A, 0);
		wr32(`MDU_ADDR_CL, 32'h80000001);
		macStep(16'h7FFF, 16'hFFFF, 32'h7FFF8002, 8'h4C, 1);
		wr32(`MDU_ADDR_CL, 32'h7FFFFFFF);
		macStep(16'h0001, 16'h0001, 32'h80000000, 8'h4E, 1);
		// Mixed signs never overflow; this also leaves the flag clear for division
		macStep(16'h0001, 16'h0001, 32'h80000001, 8'h4A, 0);
	endtask

	task automatic tDiv;
		divCase(8'h80, 32'hFFFFFFFF, 32'h00000010, 32'h0FFFFFFF, 32'h0000000F, 1);
		divCase(8'hC0, 32'h12345678, 32'h00001234, 32'h00010004, 32'h00000DA8, 0);
	endtask

	initial begin
		rst_n = 1'b0;
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		rst_n = 1'b1;
		tReset();
		tMul();
		tMac();
		tSmac();
		tDiv();
		stop_test();
	end

	// The whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge mclk);
		failures++;
		stop_test();
	end
endmodule
`default_nettype wire
